// ### src/uart_ctrl_pkg.sv
// package: register map, field positions, reset values and timing constants of the uart control block
package uart_ctrl_pkg;

    // ------------------------------------------------------------
    // register offsets (chosen, plain port address space)
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;  // global enable, frame length, break, ninth bits
    localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1;  // enables, speed, address detect, irq enables
    localparam logic [2:0] ADDR_TX_RX_DATA  = 3'h2;  // shared transmit / receive data
    localparam logic [2:0] ADDR_BAUD_DIV    = 3'h3;  // baud divider value
    localparam logic [2:0] ADDR_STATUS      = 3'h4;  // status flags, write one to clear
    localparam logic [2:0] ADDR_IRQ         = 3'h5;  // interrupt request flag, write one to clear

    // ------------------------------------------------------------
    // control one fields
    // ------------------------------------------------------------
    localparam int C1_GLOBAL_EN  = 7;  // uart_global_enable
    localparam int C1_FRAME_LEN  = 6;  // frame_length_select
    localparam int C1_SEND_BREAK = 2;  // send_break
    localparam int C1_RX_NINTH   = 1;  // rx_ninth_bit, read only
    localparam int C1_TX_NINTH   = 0;  // tx_ninth_bit, write only

    // ------------------------------------------------------------
    // control two fields
    // ------------------------------------------------------------
    localparam int C2_TX_EN      = 7;  // transmitter_enable
    localparam int C2_RX_EN      = 6;  // receiver_enable
    localparam int C2_BAUD_HIGH  = 5;  // baud_high_speed
    localparam int C2_ADDR_DET   = 4;  // address_detect_enable
    localparam int C2_WAKE_EN    = 3;  // rx pin wake-up enable
    localparam int C2_RX_IRQ     = 2;  // rx_irq_enable
    localparam int C2_TX_IDLE_IRQ = 1; // tx_idle_irq_enable
    localparam int C2_TX_EMPTY_IRQ = 0; // tx_empty_irq_enable

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int ST_OVERRUN  = 0;  // overrun_flag
    localparam int ST_RX_AVAIL = 1;  // rx_available_flag
    localparam int ST_TX_IDLE  = 2;  // tx_idle_flag
    localparam int ST_TX_EMPTY = 3;  // tx_empty_flag
    localparam int ST_RX_IDLE  = 4;  // receiver idle
    localparam int ST_FRAME_ERR = 5; // stop bit low

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;
    localparam logic [7:0] BAUD_DIV_RST    = 8'h00;
    localparam logic [5:0] STATUS_RST      = 6'h1c;  // tx idle, tx empty and rx idle set
    localparam int         BREAK_BITS      = 13;   // least break length in bit periods
    localparam int         LOW_SPEED_DIV   = 64;   // clocks per bit per divider step, low speed
    localparam int         HIGH_SPEED_DIV  = 16;   // clocks per bit per divider step, high speed

    // transmitter states
    typedef enum logic [3:0] {
        TX_IDLE  = 4'b0001,
        TX_SHIFT = 4'b0010,
        TX_BREAK = 4'b0100,
        TX_HOLD  = 4'b1000
    } tx_state_type;

endpackage : uart_ctrl_pkg

// ### src/uart_control_and_data_regs.sv
// uart control registers, shared data register and minimal frame engine
// Behaviour
// - break waits for buffer, then low >=13 bits
// - ninth received bit read at control bit 1
// - ninth transmitted bit from control bit 0
// - transmitter enable low aborts and resets transmitter
// - drive tx only with both enables
// - receiver enable low aborts and resets receiver
// - own rx only with both enables
// - speed bit selects baud generator mode
// - address when top received bit is one
// - address words raise receive interrupt
// - data words discarded under address detect
// - rx falling edge wakes sleeping chip
// - no wake-up when wake enable low
// - overrun or data available sets irq when enabled
// - transmitter idle sets irq when enabled
// - transmit empty sets irq when enabled
// - one data register, write tx, read rx
// - global disable empties, clears, sets idle flags
// - frame length: zero eight, one nine bits
module uart_control_and_data_regs (
    input  wire logic       I_CLK,       // system clock, 100 MHz
    input  wire logic       I_RST_N,     // synchronous reset, active low
    input  wire logic [2:0] I_ADDR,      // register address
    input  wire logic [7:0] I_WDATA,     // write data
    input  wire logic       I_WR,        // write strobe
    input  wire logic       I_RD,        // read strobe
    output logic      [7:0] O_RDATA,     // read data, cycle after strobe
    input  wire logic       I_RX,        // serial receive line
    output logic            O_TX,        // serial transmit line level
    output logic            O_TX_OE,     // uart owns the tx pin
    output logic            O_RX_OWN,    // uart owns the rx pin
    input  wire logic       I_SLEEP,     // chip is in idle or sleep
    output logic            O_WAKE,      // wake-up request pulse
    output logic            O_IRQ        // uart interrupt request flag
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                 ctl1_q;     // control one, bits 1 and 0 held separately
        logic [7:0]                 ctl2_q;     // control two
        logic [7:0]                 baud_q;     // baud divider value
        logic [7:0]                 rdata_q;    // read data register
        logic [5:0]                 stat_q;     // status flags
        logic                       irq_q;      // sticky interrupt request
        logic                       rx_ninth_q; // ninth received bit
        logic                       tx_ninth_q; // ninth transmit bit, write only
        logic [7:0]                 txbuf_q;    // transmit holding buffer
        logic                       txbuf_9_q;  // ninth bit held with buffer
        logic                       txfull_q;   // buffer holds a word
        logic [7:0]                 rxbuf_q;    // received word
        uart_ctrl_pkg::tx_state_type tx_st_q;   // transmitter state
        logic [10:0]                tx_sh_q;    // transmit shift register
        logic [3:0]                 tx_cnt_q;   // bits left or break bits done
        logic [13:0]                tx_tick_q;  // transmitter bit timer
        logic                       tx_line_q;  // tx line level
        logic                       rx_busy_q;  // reception in progress
        logic [9:0]                 rx_sh_q;    // receive shift register
        logic [3:0]                 rx_cnt_q;   // bits sampled
        logic [13:0]                rx_tick_q;  // receiver bit timer
        logic                       rx_prev_q;  // previous rx level
        logic                       wake_q;     // wake pulse
    } state_type;

    state_type s_q;   // registered state
    state_type s_d;   // next state

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    logic        glob_en;   // uart_global_enable
    logic        nine_bit;  // frame_length_select
    logic        tx_on;     // transmitter running
    logic        rx_on;     // receiver running
    logic [14:0] bit_len;   // clocks per bit period, 256 * 64 needs 15 bits
    logic [3:0]  frame_bits;// data bits per frame

    assign glob_en    = s_q.ctl1_q[uart_ctrl_pkg::C1_GLOBAL_EN];
    assign nine_bit   = s_q.ctl1_q[uart_ctrl_pkg::C1_FRAME_LEN];
    assign frame_bits = nine_bit ? 4'h9 : 4'h8;
    assign tx_on      = glob_en & s_q.ctl2_q[uart_ctrl_pkg::C2_TX_EN];
    assign rx_on      = glob_en & s_q.ctl2_q[uart_ctrl_pkg::C2_RX_EN];
    // speed bit picks divide by 16 or 64 per divider step
    assign bit_len = s_q.ctl2_q[uart_ctrl_pkg::C2_BAUD_HIGH]
                   ? 15'((32'(s_q.baud_q) + 1) * uart_ctrl_pkg::HIGH_SPEED_DIV)
                   : 15'((32'(s_q.baud_q) + 1) * uart_ctrl_pkg::LOW_SPEED_DIV);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic       rx_top;     // address bit of received word
        logic       rx_done;    // a frame completed this cycle
        logic [7:0] ctl1_rd;    // control one as read
        s_d     = s_q;
        rx_top  = 1'b0;
        rx_done = 1'b0;
        s_d.wake_q = 1'b0;
        ctl1_rd = s_q.ctl1_q;
        ctl1_rd[uart_ctrl_pkg::C1_RX_NINTH] = s_q.rx_ninth_q;
        ctl1_rd[uart_ctrl_pkg::C1_TX_NINTH] = 1'b0;

        // wake-up on rx falling edge while sleeping, only when enabled
        s_d.rx_prev_q = I_RX;
        if (s_q.ctl2_q[uart_ctrl_pkg::C2_WAKE_EN] && I_SLEEP && s_q.rx_prev_q && !I_RX) begin
            s_d.wake_q = 1'b1;
        end

        // ---------------- transmitter ----------------
        case (s_q.tx_st_q)
            uart_ctrl_pkg::TX_IDLE: begin
                s_d.tx_line_q = 1'b1;
                if (s_q.txfull_q) begin
                    // start, data lsb first, optional ninth bit, stop
                    s_d.tx_sh_q = nine_bit ? {1'b1, s_q.txbuf_9_q, s_q.txbuf_q, 1'b0}
                                           : {2'b11, s_q.txbuf_q, 1'b0};
                    s_d.tx_cnt_q  = frame_bits + 4'h2;
                    s_d.tx_tick_q = 14'h0;
                    s_d.txfull_q  = 1'b0;
                    s_d.stat_q[uart_ctrl_pkg::ST_TX_EMPTY] = 1'b1;
                    s_d.stat_q[uart_ctrl_pkg::ST_TX_IDLE]  = 1'b0;
                    s_d.tx_st_q   = uart_ctrl_pkg::TX_SHIFT;
                end else if (s_q.ctl1_q[uart_ctrl_pkg::C1_SEND_BREAK]) begin
                    // buffered data has gone out, now hold the line low
                    s_d.tx_cnt_q  = 4'h0;
                    s_d.tx_tick_q = 14'h0;
                    s_d.tx_st_q   = uart_ctrl_pkg::TX_BREAK;
                end
            end

            // one bit per bit period, ninth and stop bits included
            uart_ctrl_pkg::TX_SHIFT: begin
                s_d.tx_line_q = s_q.tx_sh_q[0];
                if (s_q.tx_tick_q + 14'h1 >= bit_len) begin
                    s_d.tx_tick_q = 14'h0;
                    s_d.tx_sh_q   = {1'b1, s_q.tx_sh_q[10:1]};
                    s_d.tx_cnt_q  = s_q.tx_cnt_q - 4'h1;
                    if (s_q.tx_cnt_q == 4'h1) begin
                        s_d.tx_st_q = uart_ctrl_pkg::TX_IDLE;
                        s_d.stat_q[uart_ctrl_pkg::ST_TX_IDLE] = !s_q.txfull_q;
                    end
                end else begin
                    s_d.tx_tick_q = s_q.tx_tick_q + 14'h1;
                end
            end

            // counts whole bit periods, so an early clear still gets 13
            uart_ctrl_pkg::TX_BREAK: begin
                s_d.tx_line_q = 1'b0;
                if (s_q.tx_tick_q + 14'h1 >= bit_len) begin
                    s_d.tx_tick_q = 14'h0;
                    s_d.tx_cnt_q  = s_q.tx_cnt_q + 4'h1;
                    if (s_q.tx_cnt_q == 4'(uart_ctrl_pkg::BREAK_BITS - 1)) begin
                        s_d.tx_st_q = uart_ctrl_pkg::TX_HOLD;
                    end
                end else begin
                    s_d.tx_tick_q = s_q.tx_tick_q + 14'h1;
                end
            end

            uart_ctrl_pkg::TX_HOLD: begin
                // stays low until software drops the break request
                s_d.tx_line_q = !s_q.ctl1_q[uart_ctrl_pkg::C1_SEND_BREAK];
                if (!s_q.ctl1_q[uart_ctrl_pkg::C1_SEND_BREAK]) begin
                    s_d.tx_st_q = uart_ctrl_pkg::TX_IDLE;
                end
            end

            // a lost state code falls back to idle
            default: begin
                s_d.tx_st_q = uart_ctrl_pkg::TX_IDLE;
            end
        endcase

        // ---------------- receiver ----------------
        if (!s_q.rx_busy_q) begin
            if (s_q.rx_prev_q && !I_RX) begin
                s_d.rx_busy_q = 1'b1;
                s_d.rx_cnt_q  = 4'h0;
                s_d.rx_tick_q = 14'(bit_len >> 1);   // sample mid-bit
                s_d.stat_q[uart_ctrl_pkg::ST_RX_IDLE] = 1'b0;
            end
        end else if (s_q.rx_tick_q + 14'h1 >= bit_len) begin
            s_d.rx_tick_q = 14'h0;
            s_d.rx_sh_q   = {I_RX, s_q.rx_sh_q[9:1]};
            s_d.rx_cnt_q  = s_q.rx_cnt_q + 4'h1;
            if (s_q.rx_cnt_q == frame_bits + 4'h1) begin
                rx_done       = 1'b1;
                s_d.rx_busy_q = 1'b0;
                s_d.stat_q[uart_ctrl_pkg::ST_RX_IDLE]   = 1'b1;
                s_d.stat_q[uart_ctrl_pkg::ST_FRAME_ERR] = !I_RX;
            end
        end else begin
            s_d.rx_tick_q = s_q.rx_tick_q + 14'h1;
        end

        // shift register holds start..last data bit once stop is sampled
        if (rx_done) begin
            rx_top = nine_bit ? s_q.rx_sh_q[9] : s_q.rx_sh_q[9];
            if (!s_q.ctl2_q[uart_ctrl_pkg::C2_ADDR_DET] || rx_top) begin
                if (s_q.stat_q[uart_ctrl_pkg::ST_RX_AVAIL]) begin
                    s_d.stat_q[uart_ctrl_pkg::ST_OVERRUN] = 1'b1;
                end else begin
                    s_d.rxbuf_q = nine_bit ? s_q.rx_sh_q[8:1] : s_q.rx_sh_q[9:2];
                    s_d.rx_ninth_q = nine_bit ? s_q.rx_sh_q[9] : s_q.rx_ninth_q;
                    s_d.stat_q[uart_ctrl_pkg::ST_RX_AVAIL] = 1'b1;
                end
            end
        end

        // ---------------- register writes ----------------
        if (I_WR) begin
            case (I_ADDR)
                uart_ctrl_pkg::ADDR_CONTROL_ONE: begin
                    s_d.ctl1_q     = {I_WDATA[7:2], 2'b00};
                    s_d.tx_ninth_q = I_WDATA[uart_ctrl_pkg::C1_TX_NINTH];
                end
                uart_ctrl_pkg::ADDR_CONTROL_TWO: s_d.ctl2_q = I_WDATA;
                uart_ctrl_pkg::ADDR_TX_RX_DATA: begin
                    if (tx_on) begin
                        s_d.txbuf_q   = I_WDATA;
                        s_d.txbuf_9_q = s_q.tx_ninth_q;
                        s_d.txfull_q  = 1'b1;
                        s_d.stat_q[uart_ctrl_pkg::ST_TX_EMPTY] = 1'b0;
                        s_d.stat_q[uart_ctrl_pkg::ST_TX_IDLE]  = 1'b0;
                    end
                end
                uart_ctrl_pkg::ADDR_BAUD_DIV: s_d.baud_q = I_WDATA;
                uart_ctrl_pkg::ADDR_STATUS: begin
                    // write one clears; a same-cycle set from hardware wins
                    s_d.stat_q = s_d.stat_q & ~(I_WDATA[5:0] & ~(s_d.stat_q ^ s_q.stat_q));
                end
                default: begin
                end
            endcase
        end

        // reading data consumes the received word
        if (I_RD && I_ADDR == uart_ctrl_pkg::ADDR_TX_RX_DATA && !rx_done) begin
            s_d.stat_q[uart_ctrl_pkg::ST_RX_AVAIL] = 1'b0;
        end

        // ---------------- disables ----------------
        if (!tx_on) begin
            s_d.tx_st_q   = uart_ctrl_pkg::TX_IDLE;
            s_d.txfull_q  = 1'b0;
            s_d.tx_line_q = 1'b1;
            s_d.stat_q[uart_ctrl_pkg::ST_TX_IDLE]  = 1'b1;
            s_d.stat_q[uart_ctrl_pkg::ST_TX_EMPTY] = 1'b1;
        end
        if (!rx_on) begin
            s_d.rx_busy_q = 1'b0;
            s_d.stat_q[uart_ctrl_pkg::ST_RX_IDLE] = 1'b1;
        end
        if (!glob_en) begin
            // enables, break and receive flags cleared, idle flags set
            s_d.ctl2_q[uart_ctrl_pkg::C2_TX_EN] = 1'b0;
            s_d.ctl2_q[uart_ctrl_pkg::C2_RX_EN] = 1'b0;
            s_d.ctl1_q[uart_ctrl_pkg::C1_SEND_BREAK] = 1'b0;
            s_d.stat_q = uart_ctrl_pkg::STATUS_RST;
        end

        // ---------------- interrupt flag ----------------
        if ((s_q.ctl2_q[uart_ctrl_pkg::C2_RX_IRQ] &&
                (s_d.stat_q[uart_ctrl_pkg::ST_OVERRUN] || s_d.stat_q[uart_ctrl_pkg::ST_RX_AVAIL]))
            || (s_q.ctl2_q[uart_ctrl_pkg::C2_TX_IDLE_IRQ] &&
                s_d.stat_q[uart_ctrl_pkg::ST_TX_IDLE] && !s_q.stat_q[uart_ctrl_pkg::ST_TX_IDLE])
            || (s_q.ctl2_q[uart_ctrl_pkg::C2_TX_EMPTY_IRQ] &&
                s_d.stat_q[uart_ctrl_pkg::ST_TX_EMPTY] && !s_q.stat_q[uart_ctrl_pkg::ST_TX_EMPTY]))
        begin
            s_d.irq_q = 1'b1;
        end else if (I_WR && I_ADDR == uart_ctrl_pkg::ADDR_IRQ && I_WDATA[0]) begin
            s_d.irq_q = 1'b0;
        end

        // ---------------- read data ----------------
        s_d.rdata_q = 8'h00;
        if (I_RD) begin
            case (I_ADDR)
                uart_ctrl_pkg::ADDR_CONTROL_ONE: s_d.rdata_q = ctl1_rd;
                uart_ctrl_pkg::ADDR_CONTROL_TWO: s_d.rdata_q = s_q.ctl2_q;
                uart_ctrl_pkg::ADDR_TX_RX_DATA:  s_d.rdata_q = s_q.rxbuf_q;
                uart_ctrl_pkg::ADDR_BAUD_DIV:    s_d.rdata_q = s_q.baud_q;
                uart_ctrl_pkg::ADDR_STATUS:      s_d.rdata_q = {2'b00, s_q.stat_q};
                uart_ctrl_pkg::ADDR_IRQ:         s_d.rdata_q = {7'h00, s_q.irq_q};
                default:                         s_d.rdata_q = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            s_q          <= '0;
            s_q.ctl1_q   <= uart_ctrl_pkg::CONTROL_ONE_RST;
            s_q.ctl2_q   <= uart_ctrl_pkg::CONTROL_TWO_RST;
            s_q.baud_q   <= uart_ctrl_pkg::BAUD_DIV_RST;
            s_q.stat_q   <= uart_ctrl_pkg::STATUS_RST;
            s_q.tx_st_q  <= uart_ctrl_pkg::TX_IDLE;
            s_q.tx_line_q <= 1'b1;
            s_q.rx_prev_q <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign O_RDATA  = s_q.rdata_q;
    assign O_TX     = s_q.tx_line_q;
    assign O_TX_OE  = tx_on;
    assign O_RX_OWN = rx_on;
    assign O_WAKE   = s_q.wake_q;
    assign O_IRQ    = s_q.irq_q;

endmodule : uart_control_and_data_regs

// ### tb/uart_serial_peer.sv
// partner model: remote serial device sending and sampling nine-bit frames
module uart_serial_peer #(
    parameter int BIT = 16  // clocks per bit period
) (
    input  wire logic clk,     // system clock, used as bit timebase
    input  wire logic tx_line, // line level arriving from the block
    output logic      rx_line  // line level driven toward the block
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rx_line = 1'b1;  // line idles high between frames
    // ----------------------------------------
    // start bit, nine data bits lsb first, one stop bit
    // ----------------------------------------
    task automatic send(input logic [8:0] d);
        logic [10:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask : send
    // bounded hunt for a start bit, then sample each bit in its middle
    task automatic get(output logic [8:0] d, output logic ok);
        int n;
        for (n = 0; n < 4000 && tx_line; n++) @(posedge clk);
        repeat (BIT / 2) @(posedge clk);
        ok = !tx_line && n < 4000;  // no start bit counts as a failed frame
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = tx_line;
        end
        repeat (BIT) @(posedge clk);
        ok = ok && tx_line;  // stop bit must be high
    endtask : get
endmodule : uart_serial_peer

// ### tb/uart_control_and_data_regs_properties.sv
// checker: port-level properties of the uart control block
module uart_control_and_data_regs_properties (
    input wire logic       I_CLK,    // system clock
    input wire logic       I_RST_N,  // sync reset, low
    input wire logic [2:0] I_ADDR,   // register address
    input wire logic [7:0] I_WDATA,  // write data
    input wire logic       I_WR,     // write strobe
    input wire logic       I_RD,     // read strobe
    input wire logic [7:0] O_RDATA,  // read data
    input wire logic       O_TX,     // tx level
    input wire logic       O_TX_OE,  // tx pin owned
    input wire logic       O_RX_OWN, // rx pin owned
    input wire logic       O_WAKE,   // wake pulse
    input wire logic       O_IRQ     // irq flag
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    // ----------------------------------------
    // write decodes
    // ----------------------------------------
    logic wr_one;  // control one written
    logic wr_two;  // control two written
    assign wr_one = I_WR && I_ADDR == uart_ctrl_pkg::ADDR_CONTROL_ONE;
    assign wr_two = I_WR && I_ADDR == uart_ctrl_pkg::ADDR_CONTROL_TWO;
    AST_TX_OFF: assert property (wr_two && !I_WDATA[7] |=> !O_TX_OE)
        else $error("tx pin kept after transmitter off");
    AST_RX_OFF: assert property (wr_two && !I_WDATA[6] |=> !O_RX_OWN)
        else $error("rx pin kept after receiver off");
    AST_GLOBAL_OFF: assert property (wr_one && !I_WDATA[7] |=> !O_TX_OE && !O_RX_OWN)
        else $error("pins kept after global disable");
    // a released transmitter must not leave the line low
    AST_TX_IDLE_HIGH: assert property (!O_TX_OE [*2] |-> O_TX)
        else $error("tx low while not owned");
    AST_RDATA_IDLE: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside read slot");
    AST_RDATA_UNMAPPED: assert property (I_RD && I_ADDR > 3'h5 |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    AST_WAKE_PULSE: assert property (O_WAKE |=> !O_WAKE)
        else $error("wake longer than one cycle");
    AST_NO_WAKE: assert property (wr_two && !I_WDATA[3] |-> ##3 !O_WAKE [*4])
        else $error("wake while wake-up disabled");
    AST_IRQ_STICKY: assert property (O_IRQ && !I_WR |=> O_IRQ)
        else $error("irq dropped without acknowledge");
    cover property (O_WAKE);
    cover property ($rose(O_IRQ));
    cover property (O_TX_OE && !O_TX [*8]);
endmodule : uart_control_and_data_regs_properties
bind uart_control_and_data_regs uart_control_and_data_regs_properties PROPS (
    .I_CLK, .I_RST_N, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
    .O_TX, .O_TX_OE, .O_RX_OWN, .O_WAKE, .O_IRQ
);

// ### tb/uart_control_and_data_regs_tb.sv
// testbench: register scenarios for the uart control block with a serial peer
module uart_control_and_data_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16;  // divider 0 at high speed: 16 clocks a bit
    localparam logic [2:0] C1  = uart_ctrl_pkg::ADDR_CONTROL_ONE;
    localparam logic [2:0] C2  = uart_ctrl_pkg::ADDR_CONTROL_TWO;
    localparam logic [2:0] DAT = uart_ctrl_pkg::ADDR_TX_RX_DATA;
    localparam logic [2:0] ST  = uart_ctrl_pkg::ADDR_STATUS;
    localparam logic [2:0] IRQ = uart_ctrl_pkg::ADDR_IRQ;
    logic       i_clk, i_rst_n, i_wr, i_rd, i_rx, i_sleep, ok;  // drives, peer flag
    logic [2:0] i_addr;                                         // bus address
    logic [7:0] i_wdata, o_rdata;                               // bus data
    logic       o_tx, o_tx_oe, o_rx_own, o_wake, o_irq;         // block outputs
    logic       tx_line;                                        // pin, pulled up when free
    logic [8:0] frame;                                          // frame seen by the peer
    int         n_errors = 0, n_checks = 0, k;                  // counters
    assign tx_line = o_tx_oe ? o_tx : 1'b1;
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    uart_control_and_data_regs DUT (.I_CLK(i_clk), .I_RST_N(i_rst_n), .I_ADDR(i_addr),
        .I_WDATA(i_wdata), .I_WR(i_wr), .I_RD(i_rd), .O_RDATA(o_rdata), .I_RX(i_rx),
        .O_TX(o_tx), .O_TX_OE(o_tx_oe), .O_RX_OWN(o_rx_own), .I_SLEEP(i_sleep),
        .O_WAKE(o_wake), .O_IRQ(o_irq));
    uart_serial_peer #(.BIT(BIT)) PEER (.clk(i_clk), .tx_line(tx_line), .rx_line(i_rx));
    // ----------------------------------------
    // compare, bus cycles, verdict
    // ----------------------------------------
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // write: one strobe cycle, then one idle cycle so the effect has landed
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
        @(posedge i_clk) i_wr <= 1'b0;
        @(posedge i_clk) #1;
    endtask : wr
    // read: data stands only in the cycle after the strobe, masked compare
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
        @(posedge i_clk);
        {i_rd, i_addr} <= {1'b1, a};
        @(posedge i_clk) i_rd <= 1'b0;
        #1 chk({2'b0, o_rdata & m}, {2'b0, exp});
    endtask : rd
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        {i_rst_n, i_wr, i_rd, i_sleep, i_addr, i_wdata} = '0;
        repeat (20) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1 chk({o_tx, o_tx_oe, o_rx_own, o_irq}, 10'h8);
        rd(C2, 8'h00);
        rd(ST, 8'h1c);
        rd(3'h6, 8'h00);
        wr(C1, 8'hc1);
        wr(uart_ctrl_pkg::ADDR_BAUD_DIV, 8'h00);
        wr(C2, 8'he5);
        chk({o_tx_oe, o_rx_own, o_irq}, 10'h6);
        wr(DAT, 8'ha5);
        PEER.get(frame, ok);
        chk({ok, frame}, 10'h3a5);
        chk(o_irq, 10'h1);
        wr(IRQ, 8'h01);
        chk(o_irq, 10'h0);
        PEER.send(9'h13c);
        repeat (4) @(posedge i_clk);
        chk(o_irq, 10'h1);
        rd(DAT, 8'h3c);
        rd(C1, 8'h02, 8'h02);
        wr(IRQ, 8'h01);
        chk(o_irq, 10'h0);
        // address detect, eight- then nine-bit frames: data dropped, address kept
        wr(C2, 8'hf4);
        for (int a = 0; a < 4; a++) begin
            wr(C1, a[1] ? 8'hc1 : 8'h81);
            PEER.send(a[1] ? {a[0], 8'h55} : {1'b1, a[0], 7'h55});
            repeat (4) @(posedge i_clk);
            chk(o_irq, 10'(a[0]));
            rd(ST, {6'h0, a[0], 1'b0}, 8'h02);
            if (a[0]) rd(DAT, {~a[1], 7'h55});
            wr(IRQ, 8'h01);
        end
        // break after the buffered word, held until cleared
        wr(C2, 8'he0);
        wr(DAT, 8'h3c);
        wr(C1, 8'hc4);
        PEER.get(frame, ok);
        chk({ok, frame}, 10'h33c);
        for (k = 0; k < 4 * BIT && tx_line; k++) @(posedge i_clk);
        chk(10'(k < 4 * BIT), 10'h1);
        k = 0;
        repeat (20 * BIT) @(posedge i_clk) k += !tx_line;
        chk(10'(k), 10'(20 * BIT));
        wr(C1, 8'hc0);
        repeat (BIT) @(posedge i_clk);
        chk(tx_line, 10'h1);
        // transmitter disabled mid-frame: nothing resent afterwards
        wr(DAT, 8'h00);
        for (k = 0; k < 4 * BIT && tx_line; k++) @(posedge i_clk);
        chk(10'(k < 4 * BIT), 10'h1);
        wr(C2, 8'h60);
        chk({o_tx_oe, o_tx}, 10'h1);
        wr(C2, 8'he0);
        k = 0;
        repeat (2 * BIT) @(posedge i_clk) k += !tx_line;
        chk(10'(k), 10'h0);
        // low speed: start and zero ninth bit each last 64 clocks
        wr(C2, 8'h82);
        wr(DAT, 8'hff);
        k = 0;
        repeat (12 * 64) @(posedge i_clk) k += !tx_line;
        chk(10'(k), 10'(2 * 64));
        chk(o_irq, 10'h1);
        wr(IRQ, 8'h01);
        wr(C2, 8'ha4);
        chk(o_rx_own, 10'h0);
        PEER.send(9'h1aa);
        chk(o_irq, 10'h0);
        i_sleep <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            wr(C2, e ? 8'h00 : 8'h08);
            k = 0;
            fork
                PEER.send(9'h1ff);
                repeat (3 * BIT) @(posedge i_clk) k += o_wake;
            join
            chk(10'(k), 10'(1 - e));
        end
        wr(C2, 8'hc0);
        wr(C1, 8'h00);
        chk({o_tx_oe, o_rx_own}, 10'h0);
        rd(ST, 8'h1c, 8'h1f);
        rd(C2, 8'h00, 8'hc0);
        wrap_up();
    end
endmodule : uart_control_and_data_regs_tb
